// File: src/serial_status_cfg.svh
// Register offsets, field positions, reset values and clear masks of the serial status block
`ifndef SERIAL_STATUS_CFG_SVH
`define SERIAL_STATUS_CFG_SVH

// Byte offsets on the register bus (low address byte only)
`define STATUS_OFS 8'h00
`define DATA_OFS 8'h04
`define CTRL_ONE_OFS 8'h08
`define CTRL_TWO_OFS 8'h0C

// Status register field positions
`define ST_TX_EMPTY 7
`define ST_TX_DONE 6
`define ST_RX_FULL 5
`define ST_QUIET 4
`define ST_OVERRUN 3
`define ST_NOISE 2
`define ST_FRAMING 1
`define ST_PARITY 0

// Control register one field positions
`define C1_RX_NINTH 7
`define C1_TX_NINTH 6
`define C1_LOW_POWER 5
`define C1_NINE_BIT 4
`define C1_WAKE_ADDR 3
`define C1_PARITY_EN 2
`define C1_PARITY_ODD 1
`define C1_PARITY_IRQ 0

// Control register two field positions (interrupt enables)
`define C2_TX_EMPTY_IRQ 7
`define C2_TX_DONE_IRQ 6
`define C2_RX_IRQ 5
`define C2_QUIET_IRQ 4

// Reset values
`define STATUS_RST 8'hC0
`define CTRL_ONE_RST 8'h00
`define CTRL_TWO_RST 8'h00

// Flags cleared by a data write and by a data read after a status read
`define TX_CLR_BITS 8'hC1
`define RX_CLR_BITS 8'h3F

`endif

// File: src/serial_status_frame_config.sv
// Serial status flags, frame control and register bus slave
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
`include "serial_status_cfg.svh"
`default_nettype none

module serial_status_frame_config (
  input wire logic hclk,                          // Bus clock, 250 MHz
  input wire logic hresetn,                       // Asynchronous reset, active low
  input wire logic hsel,                          // Slave select
  input wire logic [31:0] haddr,                  // Byte address
  input wire logic [1:0] htrans,                  // Transfer type
  input wire logic hwrite,                        // Write when high
  input wire logic [2:0] hsize,                   // Transfer size
  input wire logic [31:0] hwdata,                 // Write data
  input wire logic hready,                        // Bus ready
  output logic [31:0] hrdata,                     // Read data
  output logic hreadyout,                         // Slave ready
  output logic hresp,                             // Always OKAY
  input wire serial_status_pkg::tx_event_t tx_in, // Transmit shifter events
  input wire serial_status_pkg::rx_event_t rx_in, // Receive shifter events
  output serial_status_pkg::frame_cfg_t frame_cfg, // Frame settings
  output logic tx_load,                           // Pulse: shifter takes tx_word
  output logic [8:0] tx_word,                     // Word for the shifter
  output logic serial_irq                         // Shared interrupt request
);
  import serial_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Parity of the low seven or eight data bits
  function automatic logic low_parity(input logic [8:0] w, input logic nine);
    low_parity = nine ? ^w[7:0] : ^w[6:0];
  endfunction

  core_state_t s; // Registered state
  core_state_t n; // Next state
  logic acc;      // Address phase taken this cycle
  logic rx_top;   // Received bit in the parity position
  logic rx_bad;   // Received word fails the parity check
  logic [7:0] tx_src; // Holding register with top bit reworked

  // Only whole-word transfers are taken; others are ignored
  assign acc = hsel & hready & htrans[1] & (hsize == 3'h2);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  // Bus side first, hardware sets last so that a set wins over a clear
  always_comb begin
    n = s;
    n.tx_load = 1'b0;
    rx_top = 1'b0;
    rx_bad = 1'b0;
    tx_src = s.tx_hold;

    // Data phase of a write taken one cycle earlier
    if (s.wr_pend) begin
      n.wr_pend = 1'b0;
      case (s.wr_addr)
        `CTRL_ONE_OFS: begin
          // Received ninth bit is hardware-owned
          n.ctrl_one[6:0] = hwdata[6:0];
        end
        `CTRL_TWO_OFS: begin
          n.ctrl_two[7:4] = hwdata[7:4];
        end
        `DATA_OFS: begin
          n.tx_hold = hwdata[7:0];
          n.tx_hold_full = 1'b1;
          if (s.seq == SEQ_ARMED) begin
            // Only flags seen at the status read are cleared
            n.status = n.status & ~(s.clr_mask & `TX_CLR_BITS);
            n.seq = SEQ_IDLE;
          end
        end
        default: begin
          // Status is read-only; unmapped writes vanish
          n.wr_pend = 1'b0;
        end
      endcase
    end

    // Address phase
    if (acc) begin
      n.hrdata = 32'h0000_0000;
      if (hwrite) begin
        n.wr_pend = 1'b1;
        n.wr_addr = haddr[7:0];
      end else begin
        case (haddr[7:0])
          `STATUS_OFS: begin
            n.hrdata[7:0] = s.status;
            n.clr_mask = s.status;
            n.seq = SEQ_ARMED;
          end
          `DATA_OFS: begin
            n.hrdata[7:0] = s.rx_data;
            if (s.seq == SEQ_ARMED) begin
              n.status = n.status & ~(s.clr_mask & `RX_CLR_BITS);
              n.seq = SEQ_IDLE;
            end
          end
          `CTRL_ONE_OFS: begin
            n.hrdata[7:0] = s.ctrl_one;
          end
          `CTRL_TWO_OFS: begin
            n.hrdata[7:0] = s.ctrl_two;
          end
          default: begin
            // Unmapped addresses read as zero
            n.hrdata = 32'h0000_0000;
          end
        endcase
      end
    end

    // Move the holding register into the shifter once the flag is cleared
    if (tx_in.shifter_free && s.tx_hold_full && !s.status[`ST_TX_EMPTY] && !s.tx_load) begin
      // Parity replaces the top data bit; settings seen now cover the new frame
      if (s.ctrl_one[`C1_PARITY_EN]) begin
        if (s.ctrl_one[`C1_NINE_BIT]) begin
          n.tx_word = {low_parity({1'b0, tx_src}, 1'b1) ^ s.ctrl_one[`C1_PARITY_ODD], tx_src};
        end else begin
          tx_src[7] = low_parity({1'b0, s.tx_hold}, 1'b0) ^ s.ctrl_one[`C1_PARITY_ODD];
          n.tx_word = {1'b0, tx_src};
        end
      end else if (s.ctrl_one[`C1_NINE_BIT]) begin
        n.tx_word = {s.ctrl_one[`C1_TX_NINTH], tx_src};
      end else begin
        n.tx_word = {1'b0, tx_src};
      end
      n.tx_load = 1'b1;
      n.tx_hold_full = 1'b0;
      n.status[`ST_TX_EMPTY] = 1'b1;
    end

    // Only a data frame completes a transmission
    if (tx_in.frame_done && tx_in.frame_kind == FRAME_DATA) begin
      n.status[`ST_TX_DONE] = 1'b1;
    end

    // Received word
    if (rx_in.word_valid) begin
      rx_top = s.rx_par_en ? (s.ctrl_one[`C1_NINE_BIT] ? rx_in.word[8] : rx_in.word[7]) : 1'b0;
      rx_bad = s.rx_par_en &
        ((low_parity(rx_in.word, s.ctrl_one[`C1_NINE_BIT]) ^ rx_top) != s.rx_par_odd);
      if (s.status[`ST_RX_FULL]) begin
        // Held word survives; framing stays clear on overrun
        n.status[`ST_OVERRUN] = 1'b1;
      end else begin
        n.rx_data = rx_in.word[7:0];
        if (s.ctrl_one[`C1_NINE_BIT]) begin
          n.ctrl_one[`C1_RX_NINTH] = rx_in.word[8];
        end
        n.status[`ST_RX_FULL] = 1'b1;
        n.quiet_armed = 1'b1;
        if (rx_in.noise) begin
          n.status[`ST_NOISE] = 1'b1;
        end
        if (rx_in.framing) begin
          n.status[`ST_FRAMING] = 1'b1;
        end
        if (rx_bad) begin
          n.status[`ST_PARITY] = 1'b1;
        end
      end
      // New parity settings apply from the next word on
      n.rx_par_en = s.ctrl_one[`C1_PARITY_EN];
      n.rx_par_odd = s.ctrl_one[`C1_PARITY_ODD];
    end

    // Quiet line is flagged once per received word
    if (rx_in.quiet_seen && s.quiet_armed) begin
      n.status[`ST_QUIET] = 1'b1;
      n.quiet_armed = 1'b0;
    end

    // Stop only while neither shifter is mid-byte, then hold
    n.stop = n.ctrl_one[`C1_LOW_POWER] & (s.stop | ~(tx_in.busy | rx_in.busy));

    // Noise and framing have no enable of their own
    n.irq = (n.status[`ST_TX_EMPTY] & n.ctrl_two[`C2_TX_EMPTY_IRQ]) |
            (n.status[`ST_TX_DONE] & n.ctrl_two[`C2_TX_DONE_IRQ]) |
            ((n.status[`ST_RX_FULL] | n.status[`ST_OVERRUN]) & n.ctrl_two[`C2_RX_IRQ]) |
            (n.status[`ST_QUIET] & n.ctrl_two[`C2_QUIET_IRQ]) |
            (n.status[`ST_PARITY] & n.ctrl_one[`C1_PARITY_IRQ]);

    // Zero-wait slave, always OKAY
    n.ready_out = 1'b1;
    n.resp = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  // Received ninth bit is given a defined zero rather than left unknown
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.status <= `STATUS_RST;
      s.ctrl_one <= `CTRL_ONE_RST;
      s.ctrl_two <= `CTRL_TWO_RST;
      s.seq <= SEQ_IDLE;
      s.ready_out <= 1'b1;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hrdata = s.hrdata;
  assign hreadyout = s.ready_out;
  assign hresp = s.resp;
  assign tx_load = s.tx_load;
  assign tx_word = s.tx_word;
  assign serial_irq = s.irq;
  assign frame_cfg.nine_bit = s.ctrl_one[`C1_NINE_BIT];
  assign frame_cfg.wake_addr_mark = s.ctrl_one[`C1_WAKE_ADDR];
  assign frame_cfg.low_power_stop = s.stop;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_irq_gating: assert property (
    serial_irq == ((s.status[`ST_TX_EMPTY] & s.ctrl_two[`C2_TX_EMPTY_IRQ]) |
                   (s.status[`ST_TX_DONE] & s.ctrl_two[`C2_TX_DONE_IRQ]) |
                   ((s.status[`ST_RX_FULL] | s.status[`ST_OVERRUN]) & s.ctrl_two[`C2_RX_IRQ]) |
                   (s.status[`ST_QUIET] & s.ctrl_two[`C2_QUIET_IRQ]) |
                   (s.status[`ST_PARITY] & s.ctrl_one[`C1_PARITY_IRQ])))
    else $error("interrupt line disagrees with flags and enables");

  chk_load_needs_clear: assert property (
    tx_load |-> !$past(s.status[`ST_TX_EMPTY]) && $past(s.tx_hold_full))
    else $error("shifter loaded while transmit-empty was set");

  chk_load_sets_empty: assert property (
    tx_load |-> s.status[`ST_TX_EMPTY] && !s.tx_hold_full)
    else $error("transmit-empty not set on shifter load");

  chk_done_on_data: assert property (
    tx_in.frame_done && tx_in.frame_kind == FRAME_DATA |=> s.status[`ST_TX_DONE])
    else $error("transmit-done missing after data frame");

  chk_done_not_other: assert property (
    tx_in.frame_done && tx_in.frame_kind != FRAME_DATA && !s.status[`ST_TX_DONE]
    |=> !s.status[`ST_TX_DONE])
    else $error("transmit-done set by preamble or break");

  chk_rx_transfer: assert property (
    rx_in.word_valid && !s.status[`ST_RX_FULL]
    |=> s.status[`ST_RX_FULL] && s.rx_data == $past(rx_in.word[7:0]))
    else $error("received word not transferred");

  chk_overrun_keeps: assert property (
    rx_in.word_valid && s.status[`ST_RX_FULL] && !s.status[`ST_FRAMING]
    |=> s.status[`ST_OVERRUN] && $stable(s.rx_data) && !s.status[`ST_FRAMING])
    else $error("overrun handling wrong");

  chk_quiet_armed: assert property (
    $rose(s.status[`ST_QUIET]) |-> $past(s.quiet_armed) && !s.quiet_armed)
    else $error("quiet flag set without a word in between");

  chk_parity_error: assert property (
    rx_in.word_valid && !s.status[`ST_RX_FULL] && rx_bad |=> s.status[`ST_PARITY])
    else $error("parity error not flagged");

  chk_stop_follows: assert property (
    s.stop |-> s.ctrl_one[`C1_LOW_POWER])
    else $error("stopped while low-power bit is clear");

  cov_tx_frame: cover property (tx_load ##[1:200] tx_in.frame_done);
  cov_overrun: cover property (rx_in.word_valid && s.status[`ST_RX_FULL]);
  cov_seq_clear: cover property ($fell(s.status[`ST_RX_FULL]));
  cov_parity_bad: cover property (rx_in.word_valid && rx_bad);

endmodule

`default_nettype wire

// File: src/serial_status_pkg.sv
// Types shared by the serial status and frame configuration block
`default_nettype none

package serial_status_pkg;

  // Kind of frame the transmit shifter has just finished
  typedef enum logic [1:0] {
    FRAME_DATA,
    FRAME_PREAMBLE,
    FRAME_BREAK
  } frame_kind_t;

  // Clearing sequence: armed by a status read, spent by a data access
  typedef enum logic {
    SEQ_IDLE,
    SEQ_ARMED
  } seq_state_t;

  // Events from the transmit shifter
  typedef struct packed {
    logic shifter_free;       // Shifter can take a new word
    logic frame_done;         // One-cycle pulse: a frame finished
    frame_kind_t frame_kind;  // Kind of that frame
    logic busy;               // A frame is being shifted
  } tx_event_t;

  // Events from the receive shifter
  typedef struct packed {
    logic word_valid;         // One-cycle pulse: a word is complete
    logic [8:0] word;         // Received word, ninth bit on top
    logic noise;              // Noise seen in that word
    logic framing;            // Framing error or break in that word
    logic quiet_seen;         // One-cycle pulse: idle line detected
    logic busy;               // A frame is being received
  } rx_event_t;

  // Frame settings toward the shifters
  typedef struct packed {
    logic nine_bit;           // Nine data bits per frame
    logic wake_addr_mark;     // Address-mark wakeup selected
    logic low_power_stop;     // Prescalers and outputs stopped
  } frame_cfg_t;

  // Whole state of the block
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [7:0] clr_mask;
    seq_state_t seq;
    logic [7:0] rx_data;
    logic [7:0] tx_hold;
    logic tx_hold_full;
    logic quiet_armed;
    logic rx_par_en;
    logic rx_par_odd;
    logic tx_load;
    logic [8:0] tx_word;
    logic stop;
    logic irq;
    logic [31:0] hrdata;
    logic ready_out;
    logic resp;
    logic wr_pend;
    logic [7:0] wr_addr;
  } core_state_t;

endpackage

`default_nettype wire

// File: verification/serial_status_frame_config_bench.sv
// Self-checking bench for the serial status and frame control block
`include "serial_status_cfg.svh"
`default_nettype none

module serial_status_frame_config_bench;
  import serial_status_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;  // Word transfers only
  logic [31:0] hrdata;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic tx_load;
  logic serial_irq;
  logic [8:0] tx_word;
  frame_cfg_t frame_cfg;
  tx_event_t tx_in;
  rx_event_t rx_in;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int loads = 0;      // Shifter loads seen
  logic [31:0] r;     // Last read data
  logic [8:0] tw;     // Last loaded word

  assign hready = hreadyout;
  always #2 hclk = ~hclk;

  serial_status_frame_config DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tx_in(tx_in), .rx_in(rx_in), .frame_cfg(frame_cfg), .tx_load(tx_load),
    .tx_word(tx_word), .serial_irq(serial_irq));

  shifter_model partner (.hclk(hclk), .hresetn(hresetn), .tx_load(tx_load),
    .tx_in(tx_in), .rx_in(rx_in));

  ////////////////////////////////////////////////////////////////
  // Count loads and cycles; a hang ends the run
  always @(posedge hclk) begin
    cycles++;
    if (tx_load === 1'b1) begin
      loads++;
    end
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // One single bus transfer; the answer is taken at the data-phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(r, {24'h0, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  // Status read then data read: empties the receive side
  task automatic clr_rx();
    bus(1'b0, `STATUS_OFS, 8'h00);
    bus(1'b0, `DATA_OFS, 8'h00);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Give flags and the request line time to settle, then look
  task automatic irq_is(input logic e);
    idle(2);
    @(negedge hclk);
    chk({31'h0, serial_irq}, {31'h0, e});
  endtask

  // Wait a bounded time for the shifter load, keep its word
  task automatic wait_load();
    for (int i = 0; i < 20 && tx_load !== 1'b1; i++) @(negedge hclk);
    tw = tx_word;
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic test_reset();
    rd(`STATUS_OFS, 8'hC0);
    bus(1'b0, `CTRL_ONE_OFS, 8'h00);
    chk(r & 32'h7F, 32'h0);
    rd(`CTRL_TWO_OFS, 8'h00);
    rd(8'h10, 8'h00);
    wr(`STATUS_OFS, 8'h00);
    rd(`STATUS_OFS, 8'hC0);
    irq_is(1'b0);
    // The status reads above armed the clearing sequence; spend it here
    // so that the first data write of the transmit test cannot clear anything
    bus(1'b0, `DATA_OFS, 8'h00);
    rd(`STATUS_OFS, 8'hC0);
    bus(1'b0, `DATA_OFS, 8'h00);
    $display("reset test done");
  endtask

  task automatic test_tx();
    wr(`CTRL_TWO_OFS, 8'h80);
    irq_is(1'b1);
    wr(`CTRL_ONE_OFS, 8'h06);
    wr(`DATA_OFS, 8'h11);
    idle(10);
    chk(loads, 0);
    rd(`STATUS_OFS, 8'hC0);
    wr(`DATA_OFS, 8'h35);
    wait_load();
    chk(tw[7:0], 8'hB5);
    partner.preamble();
    rd(`STATUS_OFS, 8'h80);
    idle(12);
    rd(`STATUS_OFS, 8'hC0);
    wr(`CTRL_TWO_OFS, 8'h40);
    irq_is(1'b1);
    wr(`CTRL_TWO_OFS, 8'h00);
    irq_is(1'b0);
    wr(`CTRL_ONE_OFS, 8'h50);
    rd(`STATUS_OFS, 8'hC0);
    wr(`DATA_OFS, 8'hA5);
    wait_load();
    chk(tw, 9'h1A5);
    chk(frame_cfg.nine_bit, 1'b1);
    idle(12);
    $display("transmit test done");
  endtask

  task automatic test_rx();
    wr(`CTRL_ONE_OFS, 8'h00);
    wr(`CTRL_TWO_OFS, 8'h20);
    partner.recv(9'h033, 1'b0, 1'b0);
    irq_is(1'b1);
    rd(`STATUS_OFS, 8'hE0);
    partner.recv(9'h0C3, 1'b0, 1'b1);
    rd(`STATUS_OFS, 8'hE8);
    rd(`DATA_OFS, 8'h33);
    rd(`STATUS_OFS, 8'hC0);
    partner.recv(9'h044, 1'b0, 1'b0);
    rd(`DATA_OFS, 8'h44);
    rd(`STATUS_OFS, 8'hE0);
    bus(1'b0, `DATA_OFS, 8'h00);
    wr(`CTRL_TWO_OFS, 8'h00);
    partner.recv(9'h055, 1'b1, 1'b1);
    irq_is(1'b0);
    rd(`STATUS_OFS, 8'hE6);
    rd(`DATA_OFS, 8'h55);
    wr(`CTRL_ONE_OFS, 8'h05);
    partner.recv(9'h003, 1'b0, 1'b0);
    clr_rx();
    partner.recv(9'h001, 1'b0, 1'b0);
    irq_is(1'b1);
    rd(`STATUS_OFS, 8'hE1);
    wr(`CTRL_ONE_OFS, 8'h04);
    irq_is(1'b0);
    rd(`DATA_OFS, 8'h01);
    wr(`CTRL_ONE_OFS, 8'h10);
    partner.recv(9'h1AA, 1'b0, 1'b0);
    rd(`CTRL_ONE_OFS, 8'h90);
    clr_rx();
    $display("receive test done");
  endtask

  task automatic test_quiet();
    wr(`CTRL_TWO_OFS, 8'h10);
    partner.quiet();
    irq_is(1'b1);
    rd(`STATUS_OFS, 8'hD0);
    bus(1'b0, `DATA_OFS, 8'h00);
    partner.quiet();
    rd(`STATUS_OFS, 8'hC0);
    irq_is(1'b0);
    $display("quiet line test done");
  endtask

  task automatic test_cfg();
    wr(`CTRL_ONE_OFS, 8'h38);
    idle(2);
    chk({29'h0, frame_cfg}, 32'h7);
    bus(1'b0, `CTRL_ONE_OFS, 8'h00);
    chk(r & 32'h7F, 32'h38);
    wr(`CTRL_ONE_OFS, 8'h00);
    idle(2);
    chk({29'h0, frame_cfg}, 32'h0);
    $display("frame settings test done");
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence: reset, then each scenario in turn
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    test_reset();
    test_tx();
    test_rx();
    test_quiet();
    test_cfg();
    print_verdict();
  end
endmodule

`default_nettype wire

// File: verification/shifter_model.sv
// Behavioural far-side transmit and receive shifters for the status block
`default_nettype none

module shifter_model
  import serial_status_pkg::*;
(
  input wire logic hclk,     // Bus clock
  input wire logic hresetn,  // Reset, active low
  input wire logic tx_load,  // Load pulse from the block
  output tx_event_t tx_in,   // Transmit shifter events
  output rx_event_t rx_in    // Receive shifter events
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt;  // Cycles left in the data frame
  logic pre_req;    // Preamble end requested by the bench

  initial rx_in = '0;

  ////////////////////////////////////////////////////////////////
  // Frame timer: a loaded word takes eight cycles, then frees the shifter
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_in <= '{1'b1, 1'b0, FRAME_DATA, 1'b0};
      cnt <= 4'h0;
      pre_req <= 1'b0;
    end else begin
      tx_in.frame_done <= 1'b0;
      tx_in.frame_kind <= FRAME_DATA;
      if (tx_load) begin
        // Drop free at once so the block cannot load twice
        tx_in.shifter_free <= 1'b0;
        tx_in.busy <= 1'b1;
        cnt <= 4'h8;
      end else if (cnt == 4'h1) begin
        tx_in.shifter_free <= 1'b1;
        tx_in.busy <= 1'b0;
        tx_in.frame_done <= 1'b1;
        cnt <= 4'h0;
      end else begin
        if (cnt != 4'h0) begin
          cnt <= cnt - 4'h1;
        end
        // A preamble ends without data
        if (pre_req) begin
          tx_in.frame_done <= 1'b1;
          tx_in.frame_kind <= FRAME_PREAMBLE;
          pre_req <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // One received word; qualifiers are scrambled once the pulse is over
  task automatic recv(input logic [8:0] w, input logic nz, input logic fr);
    @(posedge hclk);
    rx_in.word_valid <= 1'b1;
    rx_in.word <= w;
    rx_in.noise <= nz;
    rx_in.framing <= fr;
    @(posedge hclk);
    rx_in.word_valid <= 1'b0;
    rx_in.word <= ~w;
    rx_in.noise <= ~nz;
    rx_in.framing <= ~fr;
  endtask

  // Idle line seen for one cycle
  task automatic quiet();
    @(posedge hclk);
    rx_in.quiet_seen <= 1'b1;
    @(posedge hclk);
    rx_in.quiet_seen <= 1'b0;
  endtask

  // Ask for a preamble frame end
  task automatic preamble();
    @(posedge hclk);
    pre_req <= 1'b1;
  endtask
endmodule

`default_nettype wire
